/* rtl/prs_params.svh */
// constants of the pressure sensor register bank
// assumes the serial front end hands over decoded register accesses
// Overview of operation
// RULE1 - every register is eight bits with fixed address and power-up default
// RULE2 - a register is selected by a seven-bit address
// RULE3 - host controls the device and reads results through register reads and writes
// RULE4 - host must never write the reserved address ranges
// RULE5 - host should leave the boot-loaded calibration registers unchanged
// RULE6 - calibration registers reload their factory contents at every power-up
// RULE7 - offset 08 holds reference pressure bits 7..0, reset zero
// RULE8 - offset 09 holds reference pressure bits 15..8, reset zero
// RULE9 - full reference pressure is added to pressure result before output
// RULE10 - offset 0A holds reference pressure bits 23..16, reset zero
// RULE11 - the 24-bit reference pressure is added as signed two's complement
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH

`define PRS_ADDR_W          7
`define PRS_DATA_W          8

`define PRS_OFS_REF_LOW     7'h08
`define PRS_OFS_REF_MID     7'h09
`define PRS_OFS_REF_HIGH    7'h0A
`define PRS_OFS_IDENTITY    7'h0F
`define PRS_OFS_AVG_CFG     7'h10
`define PRS_OFS_CTRL_ONE    7'h20
`define PRS_OFS_CTRL_TWO    7'h21
`define PRS_OFS_CTRL_THREE  7'h22
`define PRS_OFS_CTRL_FOUR   7'h23
`define PRS_OFS_INT_CFG     7'h24
`define PRS_OFS_INT_CAUSE   7'h25
`define PRS_OFS_STATUS      7'h27
`define PRS_OFS_POUT_LOW    7'h28
`define PRS_OFS_POUT_MID    7'h29
`define PRS_OFS_POUT_HIGH   7'h2A
`define PRS_OFS_TOUT_LOW    7'h2B
`define PRS_OFS_TOUT_HIGH   7'h2C
`define PRS_OFS_QUEUE_CTRL  7'h2E
`define PRS_OFS_QUEUE_STAT  7'h2F
`define PRS_OFS_THS_LOW     7'h30
`define PRS_OFS_THS_HIGH    7'h31
`define PRS_OFS_OFFSET_LOW  7'h39
`define PRS_OFS_OFFSET_HIGH 7'h3A

`define PRS_RST_ZERO        8'h00
`define PRS_RST_AVG_CFG     8'h05
`define PRS_AVG_CFG_MASK    8'h0F
`define PRS_FACTORY_OFS_LOW 8'h38
`define PRS_FACTORY_OFS_HI  8'h00
// arbitrary neutral identity value
`define PRS_IDENTITY_VALUE  8'hA5

`endif

/* rtl/prs_pkg.sv */
// types of the pressure sensor register bank
// assumes prs_params.svh supplies the widths
`include "prs_params.svh"

package prs_pkg;

  typedef logic [`PRS_ADDR_W-1:0] prs_addr_t;
  typedef logic [`PRS_DATA_W-1:0] prs_byte_t;
  typedef logic [23:0]            prs_press_t;
  typedef logic [15:0]            prs_temp_t;

  // access class of an address
  typedef enum logic [1:0] {
    PRS_ACC_RW,
    PRS_ACC_RO,
    PRS_ACC_RSVD
  } prs_acc_e;

endpackage

/* rtl/prs_regbank.sv */
// register bank of the barometric pressure sensor
// assumes a serial front end delivering one-cycle read and write strobes,
// and a measurement path delivering raw results with a strobe
`timescale 1ns/1ps
`default_nettype none
`include "prs_params.svh"

module prs_regbank #(
  parameter prs_pkg::prs_byte_t FACTORY_OFS_LOW = `PRS_FACTORY_OFS_LOW,
  parameter prs_pkg::prs_byte_t FACTORY_OFS_HI  = `PRS_FACTORY_OFS_HI,
  parameter prs_pkg::prs_byte_t IDENTITY        = `PRS_IDENTITY_VALUE
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // register access
  input  wire prs_pkg::prs_addr_t reg_addr,
  input  wire logic               reg_wr_en,
  input  wire logic               reg_rd_en,
  input  wire prs_pkg::prs_byte_t reg_wdata,
  output var  prs_pkg::prs_byte_t reg_rdata,
  output var  logic               reg_rvalid,
  // measurement path
  input  wire prs_pkg::prs_press_t raw_press,
  input  wire prs_pkg::prs_temp_t  raw_temp,
  input  wire logic               sample_strobe,
  input  wire prs_pkg::prs_byte_t int_cause_in,
  input  wire prs_pkg::prs_byte_t status_in,
  input  wire prs_pkg::prs_byte_t queue_status_in,
  input  wire logic               boot_req,
  // configuration outputs
  output var  prs_pkg::prs_press_t ref_pressure,
  output var  prs_pkg::prs_byte_t avg_config,
  output var  prs_pkg::prs_byte_t ctrl_one,
  output var  prs_pkg::prs_byte_t ctrl_two,
  output var  prs_pkg::prs_byte_t ctrl_three,
  output var  prs_pkg::prs_byte_t ctrl_four,
  output var  prs_pkg::prs_byte_t int_config,
  output var  prs_pkg::prs_byte_t queue_ctrl,
  output var  prs_pkg::prs_temp_t press_threshold,
  output var  prs_pkg::prs_temp_t press_offset,
  // results
  output var  prs_pkg::prs_press_t press_result,
  output var  prs_pkg::prs_temp_t  temp_result
);
  import prs_pkg::*;

  prs_byte_t  ref_low_bits_r;
  prs_byte_t  ref_middle_bits_r;
  prs_byte_t  ref_high_bits_r;
  prs_byte_t  avg_cfg_r;
  prs_byte_t  ctrl_one_r;
  prs_byte_t  ctrl_two_r;
  prs_byte_t  ctrl_three_r;
  prs_byte_t  ctrl_four_r;
  prs_byte_t  int_cfg_r;
  prs_byte_t  queue_ctrl_r;
  prs_byte_t  ths_low_r;
  prs_byte_t  ths_high_r;
  prs_byte_t  ofs_low_r;
  prs_byte_t  ofs_high_r;
  prs_byte_t  int_cause_r;
  prs_byte_t  status_r;
  prs_byte_t  queue_status_r;
  prs_press_t press_out_r;
  prs_temp_t  temp_out_r;
  prs_byte_t  rdata_r;
  prs_byte_t  rdata_nxt;
  logic       rvalid_r;
  prs_acc_e   acc_class;
  logic       wr_ok;
  prs_press_t press_sum;

  // access class per address
  always_comb
  begin
    unique case (reg_addr) // RULE2
      `PRS_OFS_REF_LOW, `PRS_OFS_REF_MID, `PRS_OFS_REF_HIGH,
      `PRS_OFS_AVG_CFG, `PRS_OFS_CTRL_ONE, `PRS_OFS_CTRL_TWO,
      `PRS_OFS_CTRL_THREE, `PRS_OFS_CTRL_FOUR, `PRS_OFS_INT_CFG,
      `PRS_OFS_QUEUE_CTRL, `PRS_OFS_THS_LOW, `PRS_OFS_THS_HIGH,
      `PRS_OFS_OFFSET_LOW, `PRS_OFS_OFFSET_HIGH:
        acc_class = PRS_ACC_RW;
      `PRS_OFS_IDENTITY, `PRS_OFS_INT_CAUSE, `PRS_OFS_STATUS,
      `PRS_OFS_POUT_LOW, `PRS_OFS_POUT_MID, `PRS_OFS_POUT_HIGH,
      `PRS_OFS_TOUT_LOW, `PRS_OFS_TOUT_HIGH, `PRS_OFS_QUEUE_STAT:
        acc_class = PRS_ACC_RO;
      default:
        acc_class = PRS_ACC_RSVD;
    endcase
  end

  // reserved and read-only addresses swallow writes
  assign wr_ok = reg_wr_en && (acc_class == PRS_ACC_RW); // RULE4

  // reference pressure bytes
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ref_low_bits_r    <= `PRS_RST_ZERO; // RULE7
      ref_middle_bits_r <= `PRS_RST_ZERO; // RULE8
      ref_high_bits_r   <= `PRS_RST_ZERO; // RULE10
    end
    else if (wr_ok)
    begin
      if (reg_addr == `PRS_OFS_REF_LOW)
        ref_low_bits_r <= reg_wdata; // RULE7
      if (reg_addr == `PRS_OFS_REF_MID)
        ref_middle_bits_r <= reg_wdata; // RULE8
      if (reg_addr == `PRS_OFS_REF_HIGH)
        ref_high_bits_r <= reg_wdata; // RULE10
    end
  end

  // configuration and control bytes
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      avg_cfg_r    <= `PRS_RST_AVG_CFG; // RULE1
      ctrl_one_r   <= `PRS_RST_ZERO;
      ctrl_two_r   <= `PRS_RST_ZERO;
      ctrl_three_r <= `PRS_RST_ZERO;
      ctrl_four_r  <= `PRS_RST_ZERO;
      int_cfg_r    <= `PRS_RST_ZERO;
      queue_ctrl_r <= `PRS_RST_ZERO;
      ths_low_r    <= `PRS_RST_ZERO;
      ths_high_r   <= `PRS_RST_ZERO;
    end
    else if (wr_ok)
    begin
      unique case (reg_addr) // RULE3
        `PRS_OFS_AVG_CFG:    avg_cfg_r    <= reg_wdata & `PRS_AVG_CFG_MASK;
        `PRS_OFS_CTRL_ONE:   ctrl_one_r   <= reg_wdata;
        `PRS_OFS_CTRL_TWO:   ctrl_two_r   <= reg_wdata;
        `PRS_OFS_CTRL_THREE: ctrl_three_r <= reg_wdata;
        `PRS_OFS_CTRL_FOUR:  ctrl_four_r  <= reg_wdata;
        `PRS_OFS_INT_CFG:    int_cfg_r    <= reg_wdata;
        `PRS_OFS_QUEUE_CTRL: queue_ctrl_r <= reg_wdata;
        `PRS_OFS_THS_LOW:    ths_low_r    <= reg_wdata;
        `PRS_OFS_THS_HIGH:   ths_high_r   <= reg_wdata;
        default:             ;
      endcase
    end
  end

  // calibration bytes, restored at power-up and by boot request
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ofs_low_r  <= FACTORY_OFS_LOW; // RULE6
      ofs_high_r <= FACTORY_OFS_HI; // RULE6
    end
    else if (boot_req)
    begin
      ofs_low_r  <= FACTORY_OFS_LOW; // RULE6
      ofs_high_r <= FACTORY_OFS_HI;
    end
    else if (wr_ok)
    begin
      // host is expected to leave these alone
      if (reg_addr == `PRS_OFS_OFFSET_LOW)
        ofs_low_r <= reg_wdata; // RULE5
      if (reg_addr == `PRS_OFS_OFFSET_HIGH)
        ofs_high_r <= reg_wdata;
    end
  end

  // status bytes mirrored from the measurement path
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      int_cause_r    <= `PRS_RST_ZERO;
      status_r       <= `PRS_RST_ZERO;
      queue_status_r <= `PRS_RST_ZERO;
    end
    else
    begin
      int_cause_r    <= int_cause_in;
      status_r       <= status_in;
      queue_status_r <= queue_status_in;
    end
  end

  // signed reference added to the raw pressure, wraps at 24 bits
  assign press_sum = 24'(signed'(raw_press) + signed'({ref_high_bits_r, ref_middle_bits_r, ref_low_bits_r})); // RULE9 RULE11

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      press_out_r <= 24'h000000;
      temp_out_r  <= 16'h0000;
    end
    else if (sample_strobe)
    begin
      press_out_r <= press_sum; // RULE9
      temp_out_r  <= raw_temp;
    end
  end

  // read mux, reserved addresses read zero
  always_comb
  begin
    rdata_nxt = `PRS_RST_ZERO;
    unique case (reg_addr)
      `PRS_OFS_REF_LOW:     rdata_nxt = ref_low_bits_r;
      `PRS_OFS_REF_MID:     rdata_nxt = ref_middle_bits_r;
      `PRS_OFS_REF_HIGH:    rdata_nxt = ref_high_bits_r;
      `PRS_OFS_IDENTITY:    rdata_nxt = IDENTITY;
      `PRS_OFS_AVG_CFG:     rdata_nxt = avg_cfg_r;
      `PRS_OFS_CTRL_ONE:    rdata_nxt = ctrl_one_r;
      `PRS_OFS_CTRL_TWO:    rdata_nxt = ctrl_two_r;
      `PRS_OFS_CTRL_THREE:  rdata_nxt = ctrl_three_r;
      `PRS_OFS_CTRL_FOUR:   rdata_nxt = ctrl_four_r;
      `PRS_OFS_INT_CFG:     rdata_nxt = int_cfg_r;
      `PRS_OFS_INT_CAUSE:   rdata_nxt = int_cause_r;
      `PRS_OFS_STATUS:      rdata_nxt = status_r;
      `PRS_OFS_POUT_LOW:    rdata_nxt = press_out_r[7:0];
      `PRS_OFS_POUT_MID:    rdata_nxt = press_out_r[15:8];
      `PRS_OFS_POUT_HIGH:   rdata_nxt = press_out_r[23:16];
      `PRS_OFS_TOUT_LOW:    rdata_nxt = temp_out_r[7:0];
      `PRS_OFS_TOUT_HIGH:   rdata_nxt = temp_out_r[15:8];
      `PRS_OFS_QUEUE_CTRL:  rdata_nxt = queue_ctrl_r;
      `PRS_OFS_QUEUE_STAT:  rdata_nxt = queue_status_r;
      `PRS_OFS_THS_LOW:     rdata_nxt = ths_low_r;
      `PRS_OFS_THS_HIGH:    rdata_nxt = ths_high_r;
      `PRS_OFS_OFFSET_LOW:  rdata_nxt = ofs_low_r;
      `PRS_OFS_OFFSET_HIGH: rdata_nxt = ofs_high_r;
      default:              rdata_nxt = `PRS_RST_ZERO;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_r  <= `PRS_RST_ZERO;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= reg_rd_en;
      if (reg_rd_en)
        rdata_r <= rdata_nxt; // RULE3
    end
  end

  // outputs
  assign reg_rdata       = rdata_r;
  assign reg_rvalid      = rvalid_r;
  assign ref_pressure    = {ref_high_bits_r, ref_middle_bits_r, ref_low_bits_r};
  assign avg_config      = avg_cfg_r;
  assign ctrl_one        = ctrl_one_r;
  assign ctrl_two        = ctrl_two_r;
  assign ctrl_three      = ctrl_three_r;
  assign ctrl_four       = ctrl_four_r;
  assign int_config      = int_cfg_r;
  assign queue_ctrl      = queue_ctrl_r;
  assign press_threshold = {ths_high_r, ths_low_r};
  assign press_offset    = {ofs_high_r, ofs_low_r};
  assign press_result    = press_out_r;
  assign temp_result     = temp_out_r;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_ref_low_write: assert property ( // RULE7
    reg_wr_en && reg_addr == `PRS_OFS_REF_LOW |=> ref_pressure[7:0] == $past(reg_wdata))
    else $error("reference low byte not written");

  a_ref_mid_write: assert property ( // RULE8
    reg_wr_en && reg_addr == `PRS_OFS_REF_MID |=> ref_pressure[15:8] == $past(reg_wdata))
    else $error("reference middle byte not written");

  a_ref_high_write: assert property ( // RULE10
    reg_wr_en && reg_addr == `PRS_OFS_REF_HIGH |=> ref_pressure[23:16] == $past(reg_wdata))
    else $error("reference high byte not written");

  a_reserved_write_ignored: assert property ( // RULE4
    reg_wr_en && acc_class == PRS_ACC_RSVD && !boot_req |=> $stable(press_offset) && $stable(ref_pressure)
      && $stable(ctrl_one) && $stable(avg_config))
    else $error("reserved write changed a register");

  a_reserved_read_zero: assert property ( // RULE2
    reg_rd_en && acc_class == PRS_ACC_RSVD |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("reserved address did not read zero");

  a_boot_restore: assert property ( // RULE6
    boot_req |=> press_offset == {FACTORY_OFS_HI, FACTORY_OFS_LOW})
    else $error("calibration not restored");

  a_signed_sum: assert property ( // RULE11
    sample_strobe |=> press_result == 24'($past(raw_press) + $past(ref_pressure)))
    else $error("pressure result not offset by reference");

  a_result_holds: assert property ( // RULE9
    !sample_strobe |=> $stable(press_result) && $stable(temp_result))
    else $error("result changed without a sample");

  a_read_latency: assert property ( // RULE3
    reg_rd_en ##1 !reg_rd_en |-> reg_rvalid ##1 !reg_rvalid)
    else $error("read answer not exactly one cycle");

  a_avg_reserved_bits: assert property ( // RULE1
    reg_wr_en && reg_addr == `PRS_OFS_AVG_CFG |=> avg_config[7:4] == 4'h0
      && avg_config[3:0] == $past(reg_wdata[3:0]))
    else $error("averaging register reserved bits not zero");

  a_ro_write_ignored: assert property ( // RULE3
    reg_wr_en && acc_class == PRS_ACC_RO && !boot_req |=> $stable(press_offset) && $stable(ref_pressure)
      && $stable(int_config) && $stable(queue_ctrl))
    else $error("read-only write changed a register");

  a_status_mirror: assert property ( // RULE3
    1'b1 |=> int_cause_r == $past(int_cause_in) && status_r == $past(status_in)
      && queue_status_r == $past(queue_status_in))
    else $error("status byte not mirrored");

  a_rdata_holds: assert property ( // RULE3
    !reg_rd_en |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  a_ctrl_write: assert property ( // RULE3
    reg_wr_en && reg_addr == `PRS_OFS_CTRL_ONE |=> ctrl_one == $past(reg_wdata))
    else $error("control byte not written");

  a_temp_capture: assert property ( // RULE3
    sample_strobe |=> temp_result == $past(raw_temp))
    else $error("temperature not captured");

  c_ref_write_then_sample: cover property (
    reg_wr_en && reg_addr == `PRS_OFS_REF_HIGH ##[1:8] sample_strobe);
  c_identity_read: cover property (
    reg_rd_en && reg_addr == `PRS_OFS_IDENTITY ##1 reg_rdata == IDENTITY);
  c_reserved_write: cover property (reg_wr_en && acc_class == PRS_ACC_RSVD);
  c_boot_after_write: cover property (
    reg_wr_en && reg_addr == `PRS_OFS_OFFSET_LOW ##[1:4] boot_req);

endmodule // prs_regbank

`default_nettype wire

/* verification/prs_host.sv */
// host model issuing register accesses to the pressure sensor bank
// assumes one clock; requests launched 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none
module prs_host (
  // clock
  input  wire logic               clk,
  // register access
  output var  prs_pkg::prs_addr_t reg_addr,
  output var  logic               reg_wr_en,
  output var  logic               reg_rd_en,
  output var  prs_pkg::prs_byte_t reg_wdata,
  input  wire prs_pkg::prs_byte_t reg_rdata,
  input  wire logic               reg_rvalid
);
  import prs_pkg::*;
  initial
  begin
    reg_addr  = 7'h7F;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = 8'hFF;
  end
  // ranges that must never be written
  function automatic logic reserved(input prs_addr_t a);
    return a inside {[7'h00:7'h07], [7'h0D:7'h0E], [7'h11:7'h1F], 7'h26, 7'h2D, [7'h32:7'h38]};
  endfunction
  task automatic wr(input prs_addr_t a, input prs_byte_t d);
    if (!reserved(a))
    begin
      @(posedge clk);
      #1 reg_wr_en = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(posedge clk);
      #1 reg_wr_en = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
    end
  endtask
  // answer one cycle after the strobe, then gone
  task automatic rd(input prs_addr_t a, output prs_byte_t d, output logic ok);
    logic v;
    @(posedge clk);
    #1 reg_rd_en = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd_en = 1'b0;
    reg_addr = ~a;
    v = reg_rvalid;
    d = reg_rdata;
    @(posedge clk);
    #1 ok = (v === 1'b1) && (reg_rvalid === 1'b0);
  endtask
endmodule // prs_host
`default_nettype wire

/* verification/tb.sv */
// self-checking bench of the pressure sensor register bank
// assumes prs_host drives the register port, the bench drives the rest
`timescale 1ns/1ps
`default_nettype none
`include "prs_params.svh"
module tb;
  import prs_pkg::*;
  logic       clk;
  logic       sys_rst;
  prs_addr_t  reg_addr;
  logic       reg_wr_en;
  logic       reg_rd_en;
  prs_byte_t  reg_wdata;
  prs_byte_t  reg_rdata;
  logic       reg_rvalid;
  prs_press_t raw_press;
  prs_temp_t  raw_temp;
  logic       sample_strobe;
  prs_byte_t  int_cause_in;
  prs_byte_t  status_in;
  prs_byte_t  queue_status_in;
  logic       boot_req;
  prs_press_t ref_pressure;
  prs_press_t press_result;
  prs_byte_t  avg_config, ctrl_one, ctrl_two, ctrl_three, ctrl_four, int_config, queue_ctrl;
  prs_temp_t  press_threshold, press_offset, temp_result;
  int         mismatches;
  int         n_checks;
  localparam logic [14:0] RST_TAB [20] = '{{7'h08, 8'h00}, {7'h09, 8'h00}, {7'h0A, 8'h00},
    {7'h0F, `PRS_IDENTITY_VALUE}, {7'h10, 8'h05}, {7'h20, 8'h00}, {7'h21, 8'h00}, {7'h22, 8'h00},
    {7'h23, 8'h00}, {7'h24, 8'h00}, {7'h25, 8'h00}, {7'h27, 8'h00}, {7'h2E, 8'h00}, {7'h2F, 8'h00},
    {7'h30, 8'h00}, {7'h31, 8'h00}, {7'h39, 8'h38}, {7'h3A, 8'h00}, {7'h00, 8'h00}, {7'h26, 8'h00}};
  localparam prs_addr_t RW_TAB [14] = '{7'h08, 7'h09, 7'h0A, 7'h10, 7'h20, 7'h21, 7'h22, 7'h23,
    7'h24, 7'h2E, 7'h30, 7'h31, 7'h39, 7'h3A};
  localparam prs_press_t SMP_TAB [10] = '{24'h000000, 24'h123456, 24'h000010, 24'h000020,
    24'hFFFFF0, 24'h000020, 24'h800000, 24'h000001, 24'hFFFFFF, 24'h000000};

  prs_regbank dut_u (.clk, .sys_rst, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata,
    .reg_rvalid, .raw_press, .raw_temp, .sample_strobe, .int_cause_in, .status_in, .queue_status_in,
    .boot_req, .ref_pressure, .avg_config, .ctrl_one, .ctrl_two, .ctrl_three, .ctrl_four, .int_config,
    .queue_ctrl, .press_threshold, .press_offset, .press_result, .temp_result);
  prs_host host_u (.clk, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata, .reg_rvalid);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input prs_addr_t a, input prs_byte_t exp);
    prs_byte_t d;
    logic      ok;
    host_u.rd(a, d, ok);
    chk($sformatf("rvalid %h", a), {23'h0, ok}, 24'h1);
    chk($sformatf("reg %h", a), {16'h0, d}, {16'h0, exp});
  endtask
  function automatic prs_byte_t pat(input prs_addr_t a);
    return {1'b0, a} ^ 8'hA6;
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #(5000 * 25);
    mismatches++;
    results();
  end

  initial
  begin
    prs_press_t e;
    mismatches = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    raw_press = 24'h0;
    raw_temp = 16'h0;
    sample_strobe = 1'b0;
    int_cause_in = 8'h00;
    status_in = 8'h00;
    queue_status_in = 8'h00;
    boot_req = 1'b0;
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    // defaults after power-up
    foreach (RST_TAB[i]) rchk(RST_TAB[i][14:8], RST_TAB[i][7:0]);
    // every writable register, read back and seen at the outputs
    foreach (RW_TAB[i]) host_u.wr(RW_TAB[i], pat(RW_TAB[i]));
    foreach (RW_TAB[i]) rchk(RW_TAB[i], (RW_TAB[i] == 7'h10) ? (pat(7'h10) & 8'h0F) : pat(RW_TAB[i]));
    chk("ref_pressure", ref_pressure, {pat(7'h0A), pat(7'h09), pat(7'h08)});
    chk("avg_config", {16'h0, avg_config}, {16'h0, pat(7'h10) & 8'h0F});
    chk("ctrl", {ctrl_one, ctrl_two, ctrl_three}, {pat(7'h20), pat(7'h21), pat(7'h22)});
    chk("ctrl_four", {ctrl_four, int_config, queue_ctrl}, {pat(7'h23), pat(7'h24), pat(7'h2E)});
    chk("threshold", {8'h0, press_threshold}, {8'h0, pat(7'h31), pat(7'h30)});
    chk("offset", {8'h0, press_offset}, {8'h0, pat(7'h3A), pat(7'h39)});
    // status mirrors; read-only and unmapped places ignore writes
    int_cause_in = 8'h3C;
    status_in = 8'hC3;
    queue_status_in = 8'h81;
    host_u.wr(7'h25, 8'hFF);
    host_u.wr(7'h7F, 8'h5A);
    rchk(7'h25, 8'h3C);
    rchk(7'h27, 8'hC3);
    rchk(7'h2F, 8'h81);
    rchk(7'h7F, 8'h00);
    // signed reference added to each sample
    for (int i = 0; i < 10; i += 2)
    begin
      host_u.wr(7'h08, SMP_TAB[i][7:0]);
      host_u.wr(7'h09, SMP_TAB[i][15:8]);
      host_u.wr(7'h0A, SMP_TAB[i][23:16]);
      e = SMP_TAB[i + 1] + SMP_TAB[i];
      @(posedge clk);
      #1 raw_press = SMP_TAB[i + 1];
      raw_temp = SMP_TAB[i + 1][15:0] ^ 16'h5A5A;
      sample_strobe = 1'b1;
      @(posedge clk);
      #1 sample_strobe = 1'b0;
      raw_press = ~raw_press;
      raw_temp = ~raw_temp;
      chk("press_result", press_result, e);
      chk("temp_result", {8'h0, temp_result}, {8'h0, SMP_TAB[i + 1][15:0] ^ 16'h5A5A});
      rchk(7'h28, e[7:0]);
      rchk(7'h29, e[15:8]);
      rchk(7'h2A, e[23:16]);
      rchk(7'h2B, SMP_TAB[i + 1][7:0] ^ 8'h5A);
      rchk(7'h2C, SMP_TAB[i + 1][15:8] ^ 8'h5A);
    end
    // calibration reload
    host_u.wr(7'h39, 8'h77);
    @(posedge clk);
    #1 boot_req = 1'b1;
    @(posedge clk);
    #1 boot_req = 1'b0;
    chk("offset boot", {8'h0, press_offset}, {8'h0, `PRS_FACTORY_OFS_HI, `PRS_FACTORY_OFS_LOW});
    rchk(7'h39, 8'h38);
    // second power-up in mid-run
    host_u.wr(7'h08, 8'hAB);
    @(posedge clk);
    #1 sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    rchk(7'h08, 8'h00);
    rchk(7'h3A, 8'h00);
    chk("press_result rst", press_result, 24'h0);
    results();
  end
endmodule // tb
`default_nettype wire
